// File: logic/acsr_regs.sv
// converter setup and counter snapshot registers behind the serial port
//
// Function
// - snapshot register low twelve bits show captured sync counter, zero after reset.
// - snapshot register bits fifteen to twelve always read zero.
// - setup bit 0 clear drives ready strobe on shared pin, set drives clock.
// - setup bit 3 picks external second voltage pair or temperature sensor.
// - setup bits five to four pick 8, 4, 2 or 1 kHz output rate.
// - writing setup bit 6 starts soft reset; bit clears itself after one cycle.
// - setup bit 7 picks filter bandwidth, 3.3 kHz when clear, 2 kHz set.
// - setup bits 1 and 2 reserved, zero, without effect.
// - lock key 0xca refuses setup writes, 0x9c accepts them again.
`timescale 1ns/1ps
`default_nettype none
module acsr_regs #(
  parameter int unsigned RATE_BASE_CYCLES = acsr_pkg::RATE_BASE_CYCLES
) (
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic                     ce,
  input  wire logic                     spi_sclk,
  input  wire logic                     spi_cs_n,
  input  wire logic                     spi_mosi,
  output var  logic                     spi_miso_out,
  output var  logic                     spi_miso_oe_n,
  output var  logic                     ready_or_clock_pin,
  output var  acsr_pkg::acsr_setup_type converter_setup
);

  // ==========================================================
  // pin synchronisers
  logic sclk_s1, sclk_s2, sclk_s3;
  logic cs_n_s1, cs_n_s2;
  logic mosi_s1, mosi_s2;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclk_s1 <= 1'b1;
      sclk_s2 <= 1'b1;
      sclk_s3 <= 1'b1;
      cs_n_s1 <= 1'b1;
      cs_n_s2 <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
    end else if (ce) begin
      sclk_s1 <= spi_sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      cs_n_s1 <= spi_cs_n;
      cs_n_s2 <= cs_n_s1;
      mosi_s1 <= spi_mosi;
      mosi_s2 <= mosi_s1;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  assign sclk_rise = sclk_s2 && !sclk_s3;
  assign sclk_fall = !sclk_s2 && sclk_s3;

  // ==========================================================
  // serial frame: command byte {addr[4:0], read, 2'b00}, then data msb first
  acsr_pkg::acsr_phase_type phase_r;
  logic [2:0]  bit_cnt_r;
  logic [7:0]  shift_in_r;
  logic [7:0]  cmd_r;
  logic [7:0]  cmd_nxt;
  logic [15:0] shift_out_r;
  logic [15:0] rd_word;
  logic        miso_r;
  logic        miso_oe_n_r;
  logic        wr_stb_r;
  logic [4:0]  wr_addr_r;
  logic [7:0]  wr_data_r;

  assign cmd_nxt = {shift_in_r[6:0], mosi_s2};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase_r     <= acsr_pkg::SPI_IDLE;
      bit_cnt_r   <= 3'h0;
      shift_in_r  <= 8'h00;
      cmd_r       <= 8'h00;
      shift_out_r <= 16'h0000;
      wr_stb_r    <= 1'b0;
      wr_addr_r   <= 5'h00;
      wr_data_r   <= 8'h00;
    end else if (ce) begin
      wr_stb_r <= 1'b0;
      case (phase_r)
        acsr_pkg::SPI_IDLE: begin
          bit_cnt_r <= 3'h0;
          if (!cs_n_s2) begin
            phase_r <= acsr_pkg::SPI_COMMAND;
          end
        end
        acsr_pkg::SPI_COMMAND: begin
          if (cs_n_s2) begin
            phase_r <= acsr_pkg::SPI_IDLE;
          end else if (sclk_rise) begin
            shift_in_r <= cmd_nxt;
            bit_cnt_r  <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7) begin
              cmd_r       <= cmd_nxt;
              shift_out_r <= rd_word;
              phase_r     <= acsr_pkg::SPI_DATA;
            end
          end
        end
        acsr_pkg::SPI_DATA: begin
          if (cs_n_s2) begin
            phase_r <= acsr_pkg::SPI_IDLE;
          end else begin
            if (sclk_rise) begin
              shift_in_r <= cmd_nxt;
              bit_cnt_r  <= bit_cnt_r + 3'h1;
              // one write per frame; later bytes are ignored
              if (bit_cnt_r == 3'h7 && !cmd_r[2] && !wr_stb_r) begin
                wr_stb_r  <= 1'b1;
                wr_addr_r <= cmd_r[7:3];
                wr_data_r <= cmd_nxt;
                cmd_r[2]  <= 1'b1;
              end
            end
            if (sclk_fall) begin
              shift_out_r <= {shift_out_r[14:0], 1'b0};
            end
          end
        end
        default: begin
          phase_r <= acsr_pkg::SPI_IDLE;
        end
      endcase
    end
  end

  // miso launched on the falling edge so the host samples it on the next rise
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      miso_r      <= 1'b0;
      miso_oe_n_r <= 1'b1;
    end else if (ce) begin
      miso_oe_n_r <= !(phase_r == acsr_pkg::SPI_DATA && !cs_n_s2);
      if (phase_r == acsr_pkg::SPI_DATA && sclk_fall) begin
        miso_r <= shift_out_r[15];
      end
    end
  end

  // ==========================================================
  // registers
  acsr_pkg::acsr_setup_type setup_r;
  logic                     lock_r;
  logic [acsr_pkg::COUNTER_WIDTH-1:0] sync_cnt_r;
  logic [15:0]              capture_r;
  logic                     setup_wr;
  logic                     snap_wr;

  assign setup_wr = wr_stb_r && wr_addr_r == acsr_pkg::ADDR_CONVERTER_SETUP;
  assign snap_wr  = wr_stb_r && wr_addr_r == acsr_pkg::ADDR_SYNC_SNAP && wr_data_r[acsr_pkg::SNAP_BIT];

  always_comb begin
    rd_word = 16'h0000;
    case (cmd_nxt[7:3])
      acsr_pkg::ADDR_SYNC_COUNTER_CAPTURE: rd_word = capture_r;
      acsr_pkg::ADDR_CONVERTER_SETUP:      rd_word = {setup_r, 8'h00};
      acsr_pkg::ADDR_STATUS0:              rd_word = {5'h00, lock_r, 2'b00, 8'h00};
      default:                             rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      setup_r <= acsr_pkg::SETUP_RESET;
    end else if (ce) begin
      // soft reset: trigger stands one cycle, then every field returns to default
      if (setup_r.soft_reset_trigger) begin
        setup_r <= acsr_pkg::SETUP_RESET;
      end else if (setup_wr && !lock_r) begin
        setup_r          <= wr_data_r;
        setup_r.reserved <= 2'b00;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lock_r <= 1'b0;
    end else if (ce) begin
      if (setup_r.soft_reset_trigger) begin
        lock_r <= 1'b0;
      end else if (wr_stb_r && wr_addr_r == acsr_pkg::ADDR_LOCK) begin
        // other key values leave protection as it was
        if (wr_data_r == acsr_pkg::LOCK_KEY_PROTECT) begin
          lock_r <= 1'b1;
        end else if (wr_data_r == acsr_pkg::LOCK_KEY_RELEASE) begin
          lock_r <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_cnt_r <= acsr_pkg::COUNTER_RESET;
      capture_r  <= acsr_pkg::CAPTURE_RESET;
    end else if (ce) begin
      sync_cnt_r <= setup_r.soft_reset_trigger ? acsr_pkg::COUNTER_RESET : sync_cnt_r + 1'b1;
      if (setup_r.soft_reset_trigger) begin
        capture_r <= acsr_pkg::CAPTURE_RESET;
      end else if (snap_wr) begin
        capture_r <= {4'h0, sync_cnt_r};
      end
    end
  end

  // ==========================================================
  // shared pin
  logic tick;
  logic pin_r;

  acsr_rate_timer #(
    .BASE_CYCLES (RATE_BASE_CYCLES)
  ) u_rate_timer (
    .clk      (clk),
    .reset    (reset),
    .ce       (ce),
    .rate_sel (setup_r.output_rate_select),
    .restart  (setup_r.soft_reset_trigger),
    .tick     (tick)
  );

  // clock mode gives clk/2; a free pin clock is not available in one domain
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_r <= 1'b0;
    end else if (ce) begin
      pin_r <= setup_r.clock_out_select ? !pin_r : tick;
    end
  end

  assign spi_miso_out       = miso_r;
  assign spi_miso_oe_n      = miso_oe_n_r;
  assign ready_or_clock_pin = pin_r;
  assign converter_setup    = setup_r;

  // ==========================================================
  // checks
  capture_upper_zero_a: assert property (@(posedge clk) disable iff (reset)
    capture_r[15:12] == 4'h0)
    else $error("snapshot reserved bits not zero");

  capture_latch_a: assert property (@(posedge clk) disable iff (reset)
    (ce && snap_wr && !setup_r.soft_reset_trigger) |=> (capture_r[11:0] == $past(sync_cnt_r)))
    else $error("snapshot did not capture counter");

  pin_ready_mode_a: assert property (@(posedge clk) disable iff (reset)
    (ce && !setup_r.clock_out_select) |=> (pin_r == $past(tick)))
    else $error("shared pin not following ready tick");

  pin_clock_mode_a: assert property (@(posedge clk) disable iff (reset)
    (ce && setup_r.clock_out_select) |=> (pin_r != $past(pin_r)))
    else $error("shared pin not toggling in clock mode");

  temp_select_a: assert property (@(posedge clk) disable iff (reset)
    (ce && setup_wr && !lock_r && !setup_r.soft_reset_trigger)
      |=> (converter_setup.temp_select == $past(wr_data_r[3])))
    else $error("temperature select not taken");

  filter_select_a: assert property (@(posedge clk) disable iff (reset)
    (ce && setup_wr && !lock_r && !setup_r.soft_reset_trigger)
      |=> (converter_setup.filter_width_select == $past(wr_data_r[7])))
    else $error("filter width select not taken");

  soft_reset_pulse_a: assert property (@(posedge clk) disable iff (reset)
    (ce && setup_r.soft_reset_trigger) |=> (setup_r == acsr_pkg::SETUP_RESET && !lock_r))
    else $error("soft reset did not self clear");

  reserved_zero_a: assert property (@(posedge clk) disable iff (reset)
    setup_r.reserved == 2'b00)
    else $error("reserved setup bits not zero");

  locked_refuse_a: assert property (@(posedge clk) disable iff (reset)
    (ce && setup_wr && lock_r && !setup_r.soft_reset_trigger) |=> $stable(setup_r))
    else $error("setup write accepted while locked");

  lock_key_a: assert property (@(posedge clk) disable iff (reset)
    (ce && wr_stb_r && wr_addr_r == acsr_pkg::ADDR_LOCK && wr_data_r == acsr_pkg::LOCK_KEY_PROTECT
      && !setup_r.soft_reset_trigger) |=> lock_r)
    else $error("protect key not taken");

  locked_write_c: cover property (@(posedge clk) disable iff (reset) setup_wr && lock_r);
  snapshot_c:     cover property (@(posedge clk) disable iff (reset) snap_wr);
  soft_reset_c:   cover property (@(posedge clk) disable iff (reset) setup_r.soft_reset_trigger);
  clock_mode_c:   cover property (@(posedge clk) disable iff (reset) setup_r.clock_out_select && pin_r);

endmodule
`default_nettype wire

// File: logic/acsr_pkg.sv
// shared constants and types of the converter setup and counter snapshot registers
`default_nettype none
package acsr_pkg;

  // ==========================================================
  // register offsets on the serial port
  localparam logic [4:0] ADDR_SYNC_COUNTER_CAPTURE = 5'h07;
  localparam logic [4:0] ADDR_CONVERTER_SETUP      = 5'h08;
  localparam logic [4:0] ADDR_STATUS0              = 5'h09;
  localparam logic [4:0] ADDR_LOCK                 = 5'h0a;
  localparam logic [4:0] ADDR_SYNC_SNAP            = 5'h0b;

  // ==========================================================
  // field layout
  // bit order of the struct is the register's own bit order, msb first
  typedef struct packed {
    logic       filter_width_select;  // bit 7
    logic       soft_reset_trigger;   // bit 6
    logic [1:0] output_rate_select;   // bits 5:4
    logic       temp_select;          // bit 3
    logic [1:0] reserved;             // bits 2:1
    logic       clock_out_select;     // bit 0
  } acsr_setup_type;

  localparam logic [7:0]  SETUP_RESET       = 8'h00;
  localparam int          SNAP_BIT          = 1;
  localparam int          STATUS_PROT_BIT   = 2;
  localparam int          COUNTER_WIDTH     = 12;
  localparam logic [11:0] COUNTER_RESET     = 12'h000;
  localparam logic [15:0] CAPTURE_RESET     = 16'h0000;
  localparam logic [7:0]  LOCK_KEY_PROTECT  = 8'hca;
  localparam logic [7:0]  LOCK_KEY_RELEASE  = 8'h9c;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_PS     = 5000;
  localparam int FAST_RATE_US      = 125;  // period at the fastest output rate
  localparam int RATE_BASE_CYCLES  = (FAST_RATE_US * 1000000) / CLK_PERIOD_PS;
  localparam int RATE_CNT_WIDTH    = 18;

  // ==========================================================
  // serial port phases
  typedef enum logic [2:0] {
    SPI_IDLE    = 3'b001,
    SPI_COMMAND = 3'b010,
    SPI_DATA    = 3'b100
  } acsr_phase_type;

endpackage
`default_nettype wire

// File: logic/acsr_rate_timer.sv
// output rate timer: one-cycle tick per selected output period
`timescale 1ns/1ps
`default_nettype none
module acsr_rate_timer #(
  parameter int unsigned BASE_CYCLES = acsr_pkg::RATE_BASE_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       ce,
  input  wire logic [1:0] rate_sel,
  input  wire logic       restart,
  output var  logic       tick
);

  // ==========================================================
  // period counter
  logic [acsr_pkg::RATE_CNT_WIDTH-1:0] cnt_r;
  logic [acsr_pkg::RATE_CNT_WIDTH-1:0] last_nxt;
  logic                                tick_r;

  // 00 -> base, 01 -> 2x, 10 -> 4x, 11 -> 8x period
  assign last_nxt = (acsr_pkg::RATE_CNT_WIDTH'(BASE_CYCLES) << rate_sel) - 1'b1;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else if (ce) begin
      // soft reset realigns the period; a rate change takes effect at once
      if (restart || cnt_r >= last_nxt) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
      tick_r <= !restart && (cnt_r >= last_nxt);
    end
  end

  assign tick = tick_r;

  // ==========================================================
  // checks
  logic [acsr_pkg::RATE_CNT_WIDTH-1:0] gap_r;
  logic                                seen_r;
  logic [1:0]                          rate_q_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gap_r    <= '0;
      seen_r   <= 1'b0;
      rate_q_r <= 2'b00;
    end else if (ce) begin
      gap_r    <= (tick_r || restart) ? '0 : gap_r + 1'b1;
      rate_q_r <= rate_sel;
      // a period cut short by a rate change is legal, so only whole periods are checked
      seen_r   <= (restart || rate_sel != rate_q_r) ? 1'b0 : (seen_r || tick_r);
    end
  end

  rate_period_a: assert property (@(posedge clk) disable iff (reset)
    (ce && tick_r && seen_r && $stable(rate_sel) && !$past(restart))
      |-> (gap_r == last_nxt))
    else $error("output rate tick spacing wrong");

endmodule
`default_nettype wire

// File: bench/acsr_host_model.sv
// host side serial port master model driving the setup register frames
`timescale 1ns/1ps
`default_nettype none
module acsr_host_model (
  input  wire logic clk,
  output var  logic sclk,
  output var  logic cs_n,
  output var  logic mosi,
  input  wire logic miso_out,
  input  wire logic miso_oe_n
);
  // above the 4 clk minimum so the two-flop sync never loses a level
  localparam int HALF = 6;

  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b1;
  end

  // ==========================================================
  // one frame: command byte, then nbits of data, msb first
  task automatic frame(input logic [7:0] cmd, input logic [15:0] wdata, input int nbits,
                       output logic [15:0] rdata);
    logic [23:0] word;
    word = {cmd, wdata};
    rdata = 16'h0000;
    @(posedge clk) cs_n <= 1'b0;
    repeat (HALF) @(posedge clk);
    for (int i = 0; i < 8 + nbits; i++) begin
      sclk <= 1'b0;
      mosi <= word[23 - i];
      repeat (HALF) @(posedge clk);
      // an undriven line counts as unknown, never as a lucky match
      if (i >= 8) rdata = {rdata[14:0], miso_oe_n ? 1'bx : miso_out};
      sclk <= 1'b1;
      repeat (HALF) @(posedge clk);
    end
    cs_n <= 1'b1;
    mosi <= ~word[16 - nbits];
    repeat (HALF) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// File: bench/acsr_regs_bench.sv
// self-checking bench of the converter setup and counter snapshot registers
`timescale 1ns/1ps
`default_nettype none
module acsr_regs_bench;
  localparam int BASE = 20;
  logic                     clk;
  logic                     reset;
  logic                     ce;
  logic                     sclk;
  logic                     cs_n;
  logic                     mosi;
  logic                     miso_out;
  logic                     miso_oe_n;
  logic                     pin;
  acsr_pkg::acsr_setup_type setup;
  logic [15:0]              rd;
  logic [7:0]               d;
  logic                     b;
  int                       failures;
  int                       checked;
  int                       sr_cnt;
  int                       sr_len;
  int                       cyc;
  int                       n;
  int                       t;

  acsr_regs #(.RATE_BASE_CYCLES(BASE)) i_acsr_regs (
    .clk(clk), .reset(reset), .ce(ce), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .spi_miso_out(miso_out), .spi_miso_oe_n(miso_oe_n), .ready_or_clock_pin(pin),
    .converter_setup(setup));

  acsr_host_model i_acsr_host_model (
    .clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso_out(miso_out), .miso_oe_n(miso_oe_n));

  // ==========================================================
  // clock, cycle count and soft reset pulse monitor
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) cyc <= reset ? 0 : cyc + 1;

  always @(negedge clk) begin
    if (setup.soft_reset_trigger === 1'b1) sr_cnt++;
    else if (sr_cnt != 0) begin
      sr_len = sr_cnt;
      sr_cnt = 0;
    end
  end

  // ==========================================================
  // helpers
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    i_acsr_host_model.frame({a, 3'b000}, {v, 8'h00}, 8, rd);
  endtask

  task automatic rdr(input logic [4:0] a, input int nb);
    i_acsr_host_model.frame({a, 3'b100}, 16'h0000, nb, rd);
  endtask

  // reserved bits and the self-clearing bit never stay set
  function automatic logic [7:0] stored(input logic [7:0] v);
    return v & 8'hb9;
  endfunction

  task automatic wait_pin(output int cnt);
    cnt = 0;
    @(negedge clk);
    while (pin !== 1'b1) begin
      @(negedge clk);
      cnt++;
      if (cnt > 400) begin
        failures++;
        results();
      end
    end
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    results();
  end

  // ==========================================================
  // main sequence
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    failures = 0;
    checked = 0;
    sr_cnt = 0;
    sr_len = 0;
    void'($urandom(32'hdc3d173b));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("setup_reset", 16'(setup), 16'(acsr_pkg::SETUP_RESET));
    rdr(acsr_pkg::ADDR_SYNC_COUNTER_CAPTURE, 16);
    check("capture_reset", rd, acsr_pkg::CAPTURE_RESET);
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom) & 8'hb9;
      d[5:4] = i[1:0];
      d[0] = i[2];
      if (i == 7) d = 8'hb9;
      wr(acsr_pkg::ADDR_CONVERTER_SETUP, d);
      check("setup_port", 16'(setup), 16'(stored(d)));
      rdr(acsr_pkg::ADDR_CONVERTER_SETUP, 8);
      check("setup_read", rd, 16'(stored(d)));
      if (d[0]) begin
        for (int k = 0; k < 4; k++) begin
          @(negedge clk) b = pin;
          @(negedge clk);
          check("clock_out", 16'(pin), 16'(!b));
        end
      end else begin
        wait_pin(n);
        @(negedge clk);
        check("strobe_width", 16'(pin), 16'h0000);
        wait_pin(n);
        check("rate_period", 16'(n + 2), 16'(BASE << d[5:4]));
      end
    end
    wr(acsr_pkg::ADDR_SYNC_SNAP, 8'h02);
    t = cyc;
    rdr(acsr_pkg::ADDR_SYNC_COUNTER_CAPTURE, 16);
    check("capture_top", 16'(rd[15:12]), 16'h0000);
    // strobe lands a few clk before the frame returns
    check("capture_count", 16'(((t + 4096 - int'(rd[11:0])) % 4096) < 16), 16'h0001);
    wr(acsr_pkg::ADDR_LOCK, acsr_pkg::LOCK_KEY_PROTECT);
    rdr(acsr_pkg::ADDR_STATUS0, 8);
    check("lock_status", 16'(rd[acsr_pkg::STATUS_PROT_BIT]), 16'h0001);
    wr(acsr_pkg::ADDR_CONVERTER_SETUP, 8'h31);
    check("locked_write", 16'(setup), 16'(stored(d)));
    wr(acsr_pkg::ADDR_LOCK, acsr_pkg::LOCK_KEY_RELEASE);
    wr(acsr_pkg::ADDR_CONVERTER_SETUP, 8'h31);
    check("unlocked_write", 16'(setup), 16'h0031);
    wr(acsr_pkg::ADDR_CONVERTER_SETUP, 8'hc1);
    check("soft_reset_pulse", 16'(sr_len), 16'h0001);
    check("soft_reset_setup", 16'(setup), 16'(acsr_pkg::SETUP_RESET));
    results();
  end
endmodule
`default_nettype wire
